// File: dca_consts.svh
// Constants for the command, address and data-lane decoder
`ifndef DCA_CONSTS_SVH
`define DCA_CONSTS_SVH
`define DCA_ROW_W 13
`define DCA_COL_W 10
`define DCA_BA_W 3
`define DCA_BANKS 8
`define DCA_DQ_W 16
`define DCA_LANES 2
`define DCA_CMD_ACT 3'h3
`define DCA_CMD_PRE 3'h2
`define DCA_CMD_RD 3'h5
`define DCA_CMD_WR 3'h4
`define DCA_CMD_MRS 3'h0
`define DCA_AP_BIT 10
`define DCA_BC_BIT 12
`define DCA_BEATS_BL8 4'h8
`define DCA_BEATS_BC4 4'h4
`endif

// File: dca_pkg.sv
// Types for the command, address and data-lane decoder
`include "dca_consts.svh"
package dca_pkg;
   typedef enum logic [2:0] {
      DCA_EV_ACT,
      DCA_EV_PRE,
      DCA_EV_PREA,
      DCA_EV_RD,
      DCA_EV_WR,
      DCA_EV_MRS,
      DCA_EV_WDATA
   } dca_ev_t;

   typedef struct packed {
      dca_ev_t kind;
      logic [2:0] ba;
      logic ap;
      logic chop;
      logic [1:0] keep;
      logic [15:0] payload;
   } dca_ev_word_t;

   typedef struct packed {
      logic cke_q;
      logic [7:0] bank_open;
      logic rd_act;
      logic wr_act;
      logic [3:0] beats;
      logic ap;
      logic [2:0] bank;
      logic [15:0] rd_word;
      logic [15:0] dq;
      logic dq_oe;
      logic [1:0] dqs;
      logic [1:0] dqs_n;
      logic dqs_oe;
      logic ev_v;
      dca_ev_word_t ev;
   } dca_ck_st_t;

   typedef struct packed {
      logic ev_v;
      dca_ev_word_t ev;
   } dca_ref_st_t;
endpackage : dca_pkg

// File: dca_xfer.sv
// Toggle-based word crossing between two clock domains
`timescale 1ns/1ps
`default_nettype none
module dca_xfer #(
   parameter int W = 16
) (
   input wire logic i_src_clk,
   input wire logic i_dst_clk,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_valid,
   output logic [W-1:0] o_data
);
   typedef struct packed {
      logic tgl;
      logic [W-1:0] data;
   } src_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic v;
      logic [W-1:0] data;
   } dst_t;

   src_t src_r;
   src_t src_nxt;
   dst_t dst_r;
   dst_t dst_nxt;

   // Source holds the word until the next event
   always_comb begin
      src_nxt = src_r;
      if (i_valid) begin
         src_nxt.tgl = ~src_r.tgl;
         src_nxt.data = i_data;
      end
   end

   always_ff @(posedge i_src_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src_r <= '0;
      end else begin
         src_r <= src_nxt;
      end
   end

   // Two-flop sync, edge seen between second and third
   always_comb begin
      dst_nxt = dst_r;
      dst_nxt.s1 = src_r.tgl;
      dst_nxt.s2 = dst_r.s1;
      dst_nxt.s3 = dst_r.s2;
      dst_nxt.v = dst_r.s2 ^ dst_r.s3;
      if (dst_r.s2 ^ dst_r.s3) begin
         dst_nxt.data = src_r.data;
      end
   end

   always_ff @(posedge i_dst_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dst_r <= '0;
      end else begin
         dst_r <= dst_nxt;
      end
   end

   assign o_valid = dst_r.v;
   assign o_data = dst_r.data;

   xfer_pulse_a: assert property (@(posedge i_dst_clk) disable iff (!i_nrst)
      dst_r.v |=> !dst_r.v)
      else $error("crossing pulse longer than one cycle");
endmodule : dca_xfer
`default_nettype wire

// File: dca_decode.sv
// Command, address and data-lane decoder at the memory pins
// Summary of operation
// [RQ1] Activate takes the full thirteen-bit row address from the address pins.
// [RQ2] Read and write take the column from the ten low address pins.
// [RQ3] Mode register set passes the address pins on as an opcode.
// [RQ4] Bit 10 high on read or write closes the bank after the burst.
// [RQ5] Precharge with bit 10 low closes one bank, high closes all.
// [RQ6] Bit 12 low on read or write chops the burst; high runs full.
// [RQ7] Chip select high masks every command; it gates cmd_ok and is not part of cmd_code.
// [RQ8] Command lines are sampled on the link clock rising edge.
// [RQ9] Select and row strobe low, others high: activate the addressed bank.
// [RQ10] Select, row strobe and write low, column high: precharge.
// [RQ11] Row strobe high, column low starts access; write picks read or write.
// [RQ12] Lower lane carries bits 0 to 7, upper lane bits 8 to 15.
// [RQ13] Each strobe has a complement; device drives pair on reads only.
// [RQ14] Read strobe edges coincide with read data changes.
// [RQ15] A write lane with its mask high is discarded.
// [RQ16] Three bank bits pick one of eight banks.
// [RQ17] Clock enable low freezes outputs and burst state from next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dca_consts.svh"
module dca_decode
   import dca_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_NRST,
   input wire logic I_CK,
   input wire logic I_CKE,
   input wire logic I_CS_N,
   input wire logic I_RAS_N,
   input wire logic I_CAS_N,
   input wire logic I_WE_N,
   input wire logic [`DCA_BA_W-1:0] I_BA,
   input wire logic [`DCA_ROW_W-1:0] I_ADDR,
   input wire logic [`DCA_LANES-1:0] I_DM,
   input wire logic [`DCA_DQ_W-1:0] I_DQ,
   output logic [`DCA_DQ_W-1:0] O_DQ,
   output logic O_DQ_OE,
   output logic [`DCA_LANES-1:0] O_DQS,
   output logic [`DCA_LANES-1:0] O_DQS_N,
   output logic O_DQS_OE,
   output logic [`DCA_BANKS-1:0] O_BANK_OPEN,
   input wire logic I_RD_LOAD,
   input wire logic [`DCA_DQ_W-1:0] I_RD_DATA,
   output logic O_EV_VALID,
   output logic [2:0] O_EV_KIND,
   output logic [`DCA_BA_W-1:0] O_BANK,
   output logic [`DCA_ROW_W-1:0] O_ADDR,
   output logic O_AUTO_PRE,
   output logic O_BURST_CHOP,
   output logic [`DCA_DQ_W-1:0] O_WDATA,
   output logic [`DCA_LANES-1:0] O_WKEEP
);
   localparam int EVW = $bits(dca_ev_word_t);

   dca_ck_st_t c_r;
   dca_ck_st_t c_nxt;
   dca_ref_st_t r_r;
   dca_ref_st_t r_nxt;

   logic evx_valid;
   logic [EVW-1:0] evx_data;
   logic rdx_valid;
   logic [`DCA_DQ_W-1:0] rdx_data;

   logic cmd_ok;
   logic [2:0] cmd_code;
   logic cmd_act;
   logic cmd_pre;
   logic cmd_rd;
   logic cmd_wr;
   logic cmd_mrs;
   logic cmd_any;

   function automatic logic [3:0] burst_len(input logic bc_n);
      burst_len = bc_n ? `DCA_BEATS_BL8 : `DCA_BEATS_BC4;
   endfunction : burst_len

   // Command decode from the sampled pins
   assign cmd_ok = c_r.cke_q && I_CKE && !I_CS_N; // RQ7
   assign cmd_code = {I_RAS_N, I_CAS_N, I_WE_N}; // RQ8
   assign cmd_act = cmd_ok && (cmd_code == `DCA_CMD_ACT); // RQ9
   assign cmd_pre = cmd_ok && (cmd_code == `DCA_CMD_PRE); // RQ10
   assign cmd_rd = cmd_ok && (cmd_code == `DCA_CMD_RD); // RQ11
   assign cmd_wr = cmd_ok && (cmd_code == `DCA_CMD_WR); // RQ11
   assign cmd_mrs = cmd_ok && (cmd_code == `DCA_CMD_MRS); // RQ3
   // Only decoded commands load the address into the event word; a NOP keeps write data
   assign cmd_any = cmd_act || cmd_pre || cmd_mrs || cmd_rd || cmd_wr; // RQ15

   // Link-side state
   always_comb begin
      c_nxt = c_r;
      c_nxt.cke_q = I_CKE;
      c_nxt.ev_v = 1'b0;
      if (rdx_valid) begin
         c_nxt.rd_word = rdx_data;
      end
      if (c_r.cke_q) begin // RQ17
         if (!(c_r.rd_act || c_r.wr_act)) begin
            c_nxt.dq_oe = 1'b0;
            c_nxt.dqs_oe = 1'b0;
         end
         if (c_r.rd_act) begin
            c_nxt.dq = c_r.rd_word;
            c_nxt.dqs = ~c_r.dqs; // RQ14
            c_nxt.dqs_n = c_r.dqs; // RQ13
         end
         if (c_r.wr_act) begin
            c_nxt.ev_v = 1'b1;
            c_nxt.ev.kind = DCA_EV_WDATA;
            c_nxt.ev.ba = c_r.bank;
            c_nxt.ev.payload = I_DQ; // RQ12
            c_nxt.ev.keep = ~I_DM; // RQ15
         end
         if (c_r.rd_act || c_r.wr_act) begin
            c_nxt.beats = c_r.beats - 4'h1;
            if (c_r.beats == 4'h1) begin
               c_nxt.rd_act = 1'b0;
               c_nxt.wr_act = 1'b0;
               if (c_r.ap) begin
                  c_nxt.bank_open[c_r.bank] = 1'b0; // RQ4
               end
            end
         end
         if (cmd_any) begin
            c_nxt.ev.ba = I_BA; // RQ16
            c_nxt.ev.ap = I_ADDR[`DCA_AP_BIT];
            c_nxt.ev.chop = !I_ADDR[`DCA_BC_BIT];
            c_nxt.ev.keep = 2'h3;
            c_nxt.ev.payload = {3'h0, I_ADDR};
         end
         if (cmd_act) begin
            c_nxt.ev_v = 1'b1;
            c_nxt.ev.kind = DCA_EV_ACT; // RQ1
            c_nxt.bank_open[I_BA] = 1'b1; // RQ9
         end
         if (cmd_pre) begin
            c_nxt.ev_v = 1'b1;
            if (I_ADDR[`DCA_AP_BIT]) begin
               c_nxt.ev.kind = DCA_EV_PREA;
               c_nxt.bank_open = 8'h00; // RQ5
            end else begin
               c_nxt.ev.kind = DCA_EV_PRE;
               c_nxt.bank_open[I_BA] = 1'b0; // RQ5
            end
         end
         if (cmd_mrs) begin
            c_nxt.ev_v = 1'b1;
            c_nxt.ev.kind = DCA_EV_MRS; // RQ3
         end
         if (cmd_rd || cmd_wr) begin
            c_nxt.ev_v = 1'b1;
            c_nxt.ev.kind = cmd_rd ? DCA_EV_RD : DCA_EV_WR;
            c_nxt.ev.payload = {6'h00, I_ADDR[`DCA_COL_W-1:0]}; // RQ2
            c_nxt.ap = I_ADDR[`DCA_AP_BIT]; // RQ4
            c_nxt.bank = I_BA;
            c_nxt.rd_act = cmd_rd;
            c_nxt.wr_act = cmd_wr;
            c_nxt.beats = burst_len(I_ADDR[`DCA_BC_BIT]); // RQ6
         end
         if (cmd_rd) begin
            c_nxt.beats = burst_len(I_ADDR[`DCA_BC_BIT]) - 4'h1; // RQ6
            c_nxt.dq = c_r.rd_word;
            c_nxt.dq_oe = 1'b1;
            c_nxt.dqs = ~c_r.dqs; // RQ14
            c_nxt.dqs_n = c_r.dqs; // RQ13
            c_nxt.dqs_oe = 1'b1; // RQ13
         end
         if (cmd_wr) begin
            c_nxt.dq_oe = 1'b0;
            c_nxt.dqs_oe = 1'b0; // RQ13
         end
      end
   end

   always_ff @(posedge I_CK or negedge I_NRST) begin
      if (!I_NRST) begin
         c_r <= '{
            dqs_n: 2'h3,
            ev: '{kind: DCA_EV_ACT, default: '0},
            default: '0
         };
      end else begin
         c_r <= c_nxt;
      end
   end

   // Events to the core clock, read words to the link clock
   dca_xfer #(
      .W(EVW)
   ) u_ev_xfer (
      .i_src_clk(I_CK),
      .i_dst_clk(I_REF_CLK),
      .i_nrst(I_NRST),
      .i_valid(c_r.ev_v),
      .i_data(c_r.ev),
      .o_valid(evx_valid),
      .o_data(evx_data)
   );

   dca_xfer #(
      .W(`DCA_DQ_W)
   ) u_rd_xfer (
      .i_src_clk(I_REF_CLK),
      .i_dst_clk(I_CK),
      .i_nrst(I_NRST),
      .i_valid(I_RD_LOAD),
      .i_data(I_RD_DATA),
      .o_valid(rdx_valid),
      .o_data(rdx_data)
   );

   // Core-side event register
   always_comb begin
      r_nxt = r_r;
      r_nxt.ev_v = evx_valid;
      if (evx_valid) begin
         r_nxt.ev = dca_ev_word_t'(evx_data);
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         r_r <= '{ev: '{kind: DCA_EV_ACT, default: '0}, default: '0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign O_DQ = c_r.dq;
   assign O_DQ_OE = c_r.dq_oe;
   assign O_DQS = c_r.dqs;
   assign O_DQS_N = c_r.dqs_n;
   assign O_DQS_OE = c_r.dqs_oe;
   assign O_BANK_OPEN = c_r.bank_open;
   assign O_EV_VALID = r_r.ev_v;
   assign O_EV_KIND = r_r.ev.kind;
   assign O_BANK = r_r.ev.ba;
   assign O_ADDR = r_r.ev.payload[`DCA_ROW_W-1:0];
   assign O_AUTO_PRE = r_r.ev.ap;
   assign O_BURST_CHOP = r_r.ev.chop;
   assign O_WDATA = r_r.ev.payload;
   assign O_WKEEP = r_r.ev.keep;

   // Checks on the link side, and one on the core side
   cs_masks_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ7
      (I_CS_N && !c_r.wr_act) |=> !c_r.ev_v)
      else $error("command accepted with select high");

   act_opens_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ9
      cmd_act |=> c_r.bank_open[$past(I_BA)] && c_r.ev.kind == DCA_EV_ACT)
      else $error("activate did not open bank");

   act_row_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ1
      cmd_act |=> c_r.ev.payload == {3'h0, $past(I_ADDR)})
      else $error("row address not taken whole");

   pre_one_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ5
      (cmd_pre && !I_ADDR[`DCA_AP_BIT]) |=>
         !c_r.bank_open[$past(I_BA)] && c_r.ev.kind == DCA_EV_PRE)
      else $error("single precharge wrong");

   pre_all_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ5
      (cmd_pre && I_ADDR[`DCA_AP_BIT]) |=> c_r.bank_open == 8'h00)
      else $error("all-bank precharge left a bank open");

   col_low_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ2
      (cmd_rd || cmd_wr) |=>
         c_r.ev.payload == {6'h00, $past(I_ADDR[`DCA_COL_W-1:0])})
      else $error("column not from low address bits");

   mrs_code_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ3
      cmd_mrs |=> c_r.ev.kind == DCA_EV_MRS &&
         c_r.ev.payload[`DCA_ROW_W-1:0] == $past(I_ADDR))
      else $error("mode opcode not passed");

   ap_flag_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ4
      (cmd_rd || cmd_wr) |=> c_r.ap == $past(I_ADDR[`DCA_AP_BIT]))
      else $error("auto precharge flag wrong");

   chop_len_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ6
      (cmd_rd && !I_ADDR[`DCA_BC_BIT]) ##1
         (c_r.cke_q && !(cmd_rd || cmd_wr))[*3] |=> !c_r.rd_act)
      else $error("chopped read burst wrong length");

   dqs_edge_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ14
      (c_r.rd_act && c_r.cke_q) |=>
         c_r.dqs != $past(c_r.dqs) && c_r.dq == $past(c_r.rd_word))
      else $error("read strobe not aligned with data");

   freeze_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ17
      !c_r.cke_q |=> $stable(c_r.dq) && $stable(c_r.beats) &&
         $stable(c_r.bank_open))
      else $error("state moved with clock enable low");

   mask_lane_a: assert property (@(posedge I_CK) disable iff (!I_NRST) // RQ15
      (c_r.wr_act && c_r.cke_q && !cmd_any) |=>
         c_r.ev.keep == ~$past(I_DM) && c_r.ev.payload == $past(I_DQ))
      else $error("write lane mask not applied");

   ev_out_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
      evx_valid |=> O_EV_VALID && O_WDATA == $past(evx_data[15:0]))
      else $error("core event not registered");

   act_c: cover property (@(posedge I_CK) disable iff (!I_NRST) cmd_act);
   rd_c: cover property (@(posedge I_CK) disable iff (!I_NRST)
      cmd_rd ##1 c_r.rd_act[*3]);
   wr_c: cover property (@(posedge I_CK) disable iff (!I_NRST)
      cmd_wr ##1 c_r.wr_act);
   prea_c: cover property (@(posedge I_CK) disable iff (!I_NRST)
      cmd_pre && I_ADDR[`DCA_AP_BIT]);
endmodule : dca_decode
`default_nettype wire

// File: dca_ctl_model.sv
// Controller-side model driving the command, address and data pins
`timescale 1ns/1ps
`default_nettype none
`include "dca_consts.svh"
module dca_ctl_model (
   output logic o_ck,
   output logic o_cke,
   output logic o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic [`DCA_BA_W-1:0] o_ba,
   output logic [`DCA_ROW_W-1:0] o_addr,
   output logic [`DCA_LANES-1:0] o_dm,
   output logic [`DCA_DQ_W-1:0] o_dq
);
   initial begin
      o_ck = 1'b0;
      o_cke = 1'b1;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
      o_ba = 3'h0;
      o_addr = 13'h0000;
      o_dm = 2'h0;
      o_dq = 16'h0000;
      #7;
      forever #62.5 o_ck = ~o_ck;
   end
   // Code is cs, ras, cas, we; all held across one whole link cycle
   task automatic put(input logic [3:0] code, input logic [2:0] ba,
         input logic [12:0] addr, input logic [1:0] dm,
         input logic [15:0] dq);
      @(posedge o_ck);
      #2;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = code;
      o_ba = ba;
      o_addr = addr;
      o_dm = dm;
      o_dq = dq;
   endtask : put
   // Deselected: lines show the inverse of their last value
   task automatic idle();
      put({1'b1, ~o_ras_n, ~o_cas_n, ~o_we_n}, ~o_ba, ~o_addr, ~o_dm,
         ~o_dq);
   endtask : idle
   task automatic set_cke(input logic v);
      @(posedge o_ck);
      #2;
      o_cke = v;
   endtask : set_cke
endmodule : dca_ctl_model
`default_nettype wire

// File: ddr3_command_address_decode_tb.sv
// Self-checking bench for the command, address and data-lane decoder
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_address_decode_tb import dca_pkg::*; ;
   logic ref_clk, nrst, rd_load;
   logic [15:0] rd_data;
   wire logic ck, cke, cs_n, ras_n, cas_n, we_n;
   wire logic [2:0] ba;
   wire logic [12:0] addr;
   wire logic [1:0] dm;
   wire logic [15:0] dq;
   logic [15:0] q, wdata;
   logic dq_oe, dqs_oe, ev_v, ev_ap, ev_chop;
   logic [1:0] dqs, dqs_n, keep;
   logic [7:0] bopen;
   logic [2:0] kind, bank;
   logic [12:0] eaddr;
   int errors, cmp_count;
   logic [38:0] evq[$];
   dca_ctl_model dca_ctl_model_i (.o_ck(ck), .o_cke(cke), .o_cs_n(cs_n),
      .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
      .o_addr(addr), .o_dm(dm), .o_dq(dq));
   dca_decode dca_decode_i (.I_REF_CLK(ref_clk), .I_NRST(nrst), .I_CK(ck),
      .I_CKE(cke), .I_CS_N(cs_n), .I_RAS_N(ras_n), .I_CAS_N(cas_n),
      .I_WE_N(we_n), .I_BA(ba), .I_ADDR(addr), .I_DM(dm), .I_DQ(dq),
      .O_DQ(q), .O_DQ_OE(dq_oe), .O_DQS(dqs), .O_DQS_N(dqs_n),
      .O_DQS_OE(dqs_oe), .O_BANK_OPEN(bopen), .I_RD_LOAD(rd_load),
      .I_RD_DATA(rd_data), .O_EV_VALID(ev_v), .O_EV_KIND(kind),
      .O_BANK(bank), .O_ADDR(eaddr), .O_AUTO_PRE(ev_ap),
      .O_BURST_CHOP(ev_chop), .O_WDATA(wdata), .O_WKEEP(keep));
   always #12.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      if (ev_v === 1'b1) begin
         evq.push_back({kind, bank, eaddr, ev_ap, ev_chop, wdata, keep});
      end
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [15:0] seen,
         input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Pops the next event, checks kind, bank and address
   task automatic ev(input logic [2:0] k, input logic [2:0] b,
         input logic [12:0] a, output logic [38:0] e);
      int n;
      n = 0;
      while (evq.size() == 0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk("event", 16'(evq.size() != 0), 16'h1);
      e = (evq.size() != 0) ? evq.pop_front() : '0;
      chk("kind", 16'(e[38:36]), 16'(k));
      chk("bank", 16'(e[35:33]), 16'(b));
      chk("addr", 16'(e[32:20]), 16'(a));
   endtask : ev
   task automatic wait_ck(input int n);
      repeat (n) @(posedge ck);
      #3;
   endtask : wait_ck
   task automatic t_act();
      logic [38:0] e;
      dca_ctl_model_i.put(4'h3, 3'h5, 13'h1abc, 2'h0, 16'h0);
      dca_ctl_model_i.idle();
      wait_ck(1);
      chk("bank_open", 16'(bopen), 16'h0020);
      ev(DCA_EV_ACT, 3'h5, 13'h1abc, e);
      $display("test act done");
   endtask : t_act
   task automatic t_masked();
      logic [3:0] codes [3];
      codes = '{4'hb, 4'h7, 4'h1};
      foreach (codes[i]) begin
         dca_ctl_model_i.put(codes[i], 3'h2, 13'h0f0f, 2'h0, 16'h0);
         dca_ctl_model_i.idle();
         wait_ck(4);
         chk("bank_open", 16'(bopen), 16'h0020);
         chk("no event", 16'(evq.size()), 16'h0);
      end
      $display("test masked done");
   endtask : t_masked
   task automatic t_rd(input logic bc_n);
      logic [38:0] e;
      logic [1:0] prev;
      int n;
      n = 0;
      prev = 2'h0;
      dca_ctl_model_i.put(4'h3, 3'h6, 13'h0123, 2'h0, 16'h0);
      dca_ctl_model_i.put(4'h5, 3'h6, {bc_n, 2'h3, 10'h2b7}, 2'h0, 16'h0);
      dca_ctl_model_i.idle();
      repeat (12) begin
         if (dq_oe === 1'b1) begin
            n++;
            chk("rd dq", q, 16'hc3a5);
            chk("dqs_n", 16'(dqs_n), {14'h0, ~dqs});
            chk("dqs_oe", 16'(dqs_oe), 16'h1);
            if (n > 1) chk("dqs toggle", 16'(dqs), {14'h0, ~prev});
         end
         prev = dqs;
         wait_ck(1);
      end
      chk("beats", 16'(n), bc_n ? 16'h8 : 16'h4);
      chk("ap close", 16'(bopen[6]), 16'h0);
      ev(DCA_EV_ACT, 3'h6, 13'h0123, e);
      ev(DCA_EV_RD, 3'h6, 13'h02b7, e);
      chk("auto_pre", 16'(e[19]), 16'h1);
      chk("chop", 16'(e[18]), {15'h0, ~bc_n});
      $display("test read done");
   endtask : t_rd
   task automatic t_wr();
      logic [38:0] e;
      logic [15:0] m;
      dca_ctl_model_i.put(4'h3, 3'h1, 13'h0777, 2'h0, 16'h0);
      dca_ctl_model_i.put(4'h4, 3'h1, 13'h03c1, 2'h0, 16'h0);
      for (int i = 0; i < 5; i++) begin
         dca_ctl_model_i.put(i[0] ? 4'h7 : 4'hf, 3'h0, 13'h0, 2'(i),
            16'(16'h1122 * (i + 1)));
      end
      dca_ctl_model_i.idle();
      wait_ck(4);
      chk("bank kept", 16'(bopen[1]), 16'h1);
      ev(DCA_EV_ACT, 3'h1, 13'h0777, e);
      ev(DCA_EV_WR, 3'h1, 13'h03c1, e);
      chk("ap", 16'(e[19]), 16'h0);
      chk("chop", 16'(e[18]), 16'h1);
      for (int i = 0; i < 4; i++) begin
         ev(DCA_EV_WDATA, 3'h1, 13'(16'h1122 * (i + 1)), e);
         chk("keep", 16'(e[1:0]), {14'h0, ~2'(i)});
         m = {{8{~i[1]}}, {8{~i[0]}}};
         chk("wdata", e[17:2] & m, (16'h1122 * (i + 1)) & m);
      end
      chk("no event", 16'(evq.size()), 16'h0);
      $display("test write done");
   endtask : t_wr
   task automatic t_pre_mrs();
      logic [38:0] e;
      dca_ctl_model_i.put(4'h2, 3'h5, 13'h0000, 2'h0, 16'h0);
      dca_ctl_model_i.idle();
      wait_ck(1);
      chk("one bank", 16'(bopen), 16'h0002);
      dca_ctl_model_i.put(4'h2, 3'h3, 13'h0400, 2'h0, 16'h0);
      dca_ctl_model_i.put(4'h0, 3'h2, 13'h0a5a, 2'h0, 16'h0);
      dca_ctl_model_i.idle();
      wait_ck(1);
      chk("all banks", 16'(bopen), 16'h0000);
      ev(DCA_EV_PRE, 3'h5, 13'h0000, e);
      ev(DCA_EV_PREA, 3'h3, 13'h0400, e);
      ev(DCA_EV_MRS, 3'h2, 13'h0a5a, e);
      $display("test precharge mrs done");
   endtask : t_pre_mrs
   task automatic t_cke();
      logic [38:0] e;
      dca_ctl_model_i.set_cke(1'b0);
      dca_ctl_model_i.put(4'h3, 3'h3, 13'h0042, 2'h0, 16'h0);
      dca_ctl_model_i.idle();
      wait_ck(4);
      chk("frozen", 16'(bopen), 16'h0000);
      chk("no event", 16'(evq.size()), 16'h0);
      dca_ctl_model_i.set_cke(1'b1);
      dca_ctl_model_i.put(4'h3, 3'h3, 13'h0042, 2'h0, 16'h0);
      dca_ctl_model_i.idle();
      wait_ck(1);
      chk("resumed", 16'(bopen), 16'h0008);
      ev(DCA_EV_ACT, 3'h3, 13'h0042, e);
      $display("test cke done");
   endtask : t_cke
   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      rd_load = 1'b0;
      rd_data = 16'h0000;
      repeat (16) @(posedge ref_clk);
      #2;
      nrst = 1'b1;
      wait_ck(2);
      @(posedge ref_clk);
      #2;
      rd_load = 1'b1;
      rd_data = 16'hc3a5;
      @(posedge ref_clk);
      #2;
      rd_load = 1'b0;
      wait_ck(5);
      t_act();
      t_masked();
      t_rd(1'b1);
      t_rd(1'b0);
      t_wr();
      t_pre_mrs();
      t_cke();
      stop_test();
   end
   initial begin
      #200000;
      errors++;
      stop_test();
   end
endmodule : ddr3_command_address_decode_tb
`default_nettype wire
